// File: shared/secc_pkg.sv
// Notes on behaviour
// - Write enable latch is clear after reset; writes need a prior write-enable command.
// - Successful write-disable, writes, status writes, erases or power-down clear the latch.
// - Frame ending off a byte boundary executes nothing and leaves the latch alone.
// - Write-disable clears the latch regardless of the write-protect pin.
// - Status read shifts out status byte 1: progress flag, latch, protection bits.
// - Status byte 1 write changes only block protect, auto power-down, standby, write-disable.
// - With write-protect low and status-write-disable set, that bit cannot be cleared.
// - Status byte 2 write sets slow oscillator and auto deep sleep, needs the latch.
// - Accepted status byte 2 write raises progress flag; completion clears flag and latch.
// - Read takes two address bytes; only the low address bits are used.
// - After read header the input is ignored and data goes out MSB first.
// - Continuous read increments the address and wraps from the top to zero.
// - Fast read takes eight dummy bits after the address before data starts.
// - Chip select rise right after the last data bit starts the internal write.
// - During the internal write every command except status read is ignored.
// - Status bit 0 reads one while a write runs and zero afterwards.
// - Write data address wraps inside the page; upper address bits are held.
// - More than a page of data keeps only the last page worth of bytes.
// - Short writes change only the addressed bytes of the page.
// - Memory write without the latch set is ignored until the next frame.
// - Auto deep sleep bit sends the device to deep sleep after memory or status1 write.
// - Slow oscillator bit stretches the write timer to lower average current.
package secc_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS1_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS2_WRITE = 8'h31;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0B;
  localparam logic [7:0] OP_WRITE         = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE    = 8'h42;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
  localparam logic [7:0] OP_POWER_DOWN    = 8'hB9;
  localparam logic [7:0] OP_RESUME        = 8'hAB;
  // Status byte 1 field positions
  localparam int S1_WIP   = 0;
  localparam int S1_WEL   = 1;
  localparam int S1_BP0   = 2;
  localparam int S1_BP1   = 3;
  localparam int S1_DEEP  = 4;
  localparam int S1_AUTO_POWERDOWN_ENABLE_BIT  = 5;
  localparam int S1_LOW_POWER_STANDBY_ENABLE_BIT  = 6;
  localparam int S1_STATUS_WRITE_DISABLE_BIT  = 7;
  // Status byte 2 field positions
  localparam int S2_SLOW  = 0;
  localparam int S2_AUTO_ULTRA_DEEP_SLEEP_BIT = 1;
  // Frame lengths in bytes
  localparam logic [7:0] READ_HDR_BYTES   = 8'h03;
  localparam logic [7:0] FAST_HDR_BYTES   = 8'h04;
  localparam logic [7:0] WRITE_MIN_BYTES  = 8'h04;
  localparam logic [7:0] STATUS_WR_BYTES  = 8'h02;
  localparam logic [7:0] ERASE_PAGE_BYTES = 8'h03;
  // Array geometry and reset values
  localparam int MEM_ADDR_BITS = 12;
  localparam int PAGE_BYTES    = 32;
  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [1:0] STATUS2_RESET = 2'h0;
  // Internal cycle lengths in clk cycles
  localparam int WRITE_CYCLES  = 64;
  localparam int STATUS_CYCLES = 32;
endpackage : secc_pkg

// File: design/secc_link.sv
`timescale 1ns/10ps
module secc_link #(
  parameter int AW = secc_pkg::MEM_ADDR_BITS,
  parameter int PB = secc_pkg::PAGE_BYTES
) (
  input  wire logic            sck,
  input  wire logic            csN,
  input  wire logic            rstn,
  input  wire logic            sdi,
  input  wire logic [7:0]      memRdData,
  input  wire logic [9:0]      linkState,
  output logic      [AW-1:0]   memRdAddr,
  output logic      [7:0]      opcode,
  output logic      [2:0]      bitPhase,
  output logic      [7:0]      byteCnt,
  output logic      [15:0]     addr,
  output logic      [PB*8-1:0] pageData,
  output logic      [PB-1:0]   pageValid,
  output logic                 sdo,
  output logic                 sdoOe
);
  import secc_pkg::*;
  localparam int PW = $clog2(PB);
  typedef struct packed {
    logic [7:0]      shiftIn;
    logic [2:0]      bitPhase;
    logic [7:0]      byteCnt;
    logic [7:0]      opcode;
    logic [15:0]     addr;
    logic [PW-1:0]   pagePtr;
    logic [PB-1:0]   pageValid;
    logic [PB*8-1:0] pageData;
    logic [7:0]      txShift;
    logic            txActive;
    logic [AW-1:0]   rdAddr;
    logic [9:0]      xMeta;
    logic [9:0]      xSync;
  } secc_link_t;
  secc_link_t q, d, s;
  logic frameRst, frameNew_q, byteDone, readOk, startRd, contRd, startSt, contSt;
  logic [7:0] inByte;
  logic [15:0] hdrAddr;
  // Frame state is held while csN is high so the clk side can read it
  assign frameRst = csN | ~rstn;
  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) frameNew_q <= 1'b1;
    else frameNew_q <= 1'b0;
  end
  always_comb begin
    s = q;
    if (frameNew_q) begin
      s.bitPhase  = '0;
      s.byteCnt   = '0;
      s.txActive  = 1'b0;
    end
    d = s;
    d.xMeta = linkState;
    d.xSync = q.xMeta;
    inByte = {s.shiftIn[6:0], sdi};
    d.shiftIn = inByte;
    d.bitPhase = s.bitPhase + 3'h1;
    d.txShift = {s.txShift[6:0], 1'b0};
    byteDone = (s.bitPhase == 3'h7);
    readOk = ~q.xSync[8] & ~q.xSync[9];
    startRd = byteDone && readOk && ((s.opcode == OP_READ && s.byteCnt == 8'h02)
                                  || (s.opcode == OP_FAST_READ && s.byteCnt == 8'h03));
    contRd = byteDone && s.txActive && (s.opcode == OP_READ || s.opcode == OP_FAST_READ);
    startSt = byteDone && s.byteCnt == 8'h00 && inByte == OP_STATUS_READ && ~q.xSync[9];
    contSt = byteDone && s.txActive && s.opcode == OP_STATUS_READ;
    hdrAddr = {s.addr[15:8], inByte};
    memRdAddr = s.rdAddr;
    if (startRd) begin
      memRdAddr = (s.opcode == OP_READ) ? hdrAddr[AW-1:0] : s.addr[AW-1:0];
    end
    if (byteDone) begin
      if (s.byteCnt != 8'hFF) d.byteCnt = s.byteCnt + 8'h01;
      case (s.byteCnt)
        8'h00: begin
          d.opcode = inByte;
          // Buffer is kept until a write is taken, since the page copy may still be reading it
          if (inByte == OP_WRITE && readOk) begin
            d.pageValid = '0;
          end
        end
        8'h01: d.addr[15:8] = inByte;
        8'h02: begin
          d.addr[7:0] = inByte;
          d.pagePtr = inByte[PW-1:0];
        end
        default: begin
          if (s.opcode == OP_WRITE && ~q.xSync[8]) begin
            d.pageData[s.pagePtr*8 +: 8] = inByte;
            d.pageValid[s.pagePtr] = 1'b1;
            d.pagePtr = s.pagePtr + 1'b1;
          end
        end
      endcase
    end
    if (startRd || contRd) begin
      d.txShift = memRdData;
      d.rdAddr = memRdAddr + 1'b1;
      d.txActive = 1'b1;
    end
    if (startSt || contSt) begin
      d.txShift = q.xSync[7:0];
      d.txActive = 1'b1;
    end
  end
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) q <= '0;
    else q <= d;
  end
  // Output moves on the falling edge so the host samples a settled bit
  always_ff @(negedge sck or posedge frameRst) begin
    if (frameRst) begin
      sdo   <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      sdo   <= q.txShift[7];
      sdoOe <= q.txActive;
    end
  end
  assign opcode    = q.opcode;
  assign bitPhase  = q.bitPhase;
  assign byteCnt   = q.byteCnt;
  assign addr      = q.addr;
  assign pageData  = q.pageData;
  assign pageValid = q.pageValid;
endmodule : secc_link

// File: design/secc_core.sv
`timescale 1ns/10ps
module secc_core #(
  parameter int AW     = secc_pkg::MEM_ADDR_BITS,
  parameter int PB     = secc_pkg::PAGE_BYTES,
  parameter int WR_CYC = secc_pkg::WRITE_CYCLES,
  parameter int ST_CYC = secc_pkg::STATUS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic sdi,
  input  wire logic wpN,
  input  wire logic deepSleepExit,
  output logic      sdo,
  output logic      sdoOe,
  output logic      writeBusy,
  output logic      deepSleep,
  output logic      powerDown,
  output logic      autoPowerDownEn,
  output logic      lowPowerStandbyEn
);
  import secc_pkg::*;

  localparam int PW = $clog2(PB);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PAGE = 2'b01,
    ST_WAIT = 2'b10
  } secc_state_t;

  typedef enum logic [1:0] {
    JOB_MEM  = 2'b00,
    JOB_STS1 = 2'b01,
    JOB_STS2 = 2'b10
  } secc_job_t;

  typedef struct packed {
    logic [2:0]    csSync;
    logic [2:0]    wpSync;
    logic          csLevel;
    logic          wpLevel;
    logic          write_enable_latch;
    logic          write_in_progress_flag;
    logic [1:0]    bp;
    logic          auto_powerdown_enable_bit;
    logic          low_power_standby_enable_bit;
    logic          status_write_disable_bit;
    logic          slow_oscillator_bit;
    logic          autoDeep;
    logic          deepSleep;
    logic          powerDown;
    secc_state_t   state;
    secc_job_t     job;
    logic [PW-1:0] idx;
    logic [15:0]   timer;
    logic          slowTick;
    logic [AW-1:0] pageBase;
    logic [9:0]    linkState;
  } secc_core_t;

  secc_core_t q;
  secc_core_t d;

  // Byte array; written only while the link side refuses reads, so the
  // link clock may look at it without a crossing
  logic [7:0]      mem [2**AW];
  logic            memWe;
  logic [AW-1:0]   memWa;
  logic [7:0]      memWd;

  logic [AW-1:0]   memRdAddr;
  logic [7:0]      memRdData;
  logic [7:0]      opcode;
  logic [2:0]      bitPhase;
  logic [7:0]      byteCnt;
  logic [15:0]     addr;
  logic [PB*8-1:0] pageData;
  logic [PB-1:0]   pageValid;

  logic            frameEnd;
  logic            wholeBytes;
  logic            hwLocked;
  logic [AW-1:0]   wrAddr;
  logic [7:0]      newStatus;

  // Upper part of the array that the block protect pair shields
  function automatic logic isProtected(input logic [1:0] bp, input logic [AW-1:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'b01:   hit = (a[AW-1:AW-2] == 2'b11);
      2'b10:   hit = a[AW-1];
      2'b11:   hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : isProtected

  // Commands that only run with the latch set and clear it when done
  function automatic logic needsLatch(input logic [7:0] op);
    logic need;
    need = 1'b0;
    case (op)
      OP_WRITE,
      OP_STATUS1_WRITE,
      OP_STATUS2_WRITE,
      OP_PAGE_ERASE,
      OP_CHIP_ERASE_A,
      OP_CHIP_ERASE_B: need = 1'b1;
      default:         need = 1'b0;
    endcase
    return need;
  endfunction : needsLatch

  function automatic logic [7:0] statusByte(input secc_core_t c);
    logic [7:0] b;
    b = STATUS1_RESET;
    b[S1_WIP]  = c.write_in_progress_flag;
    b[S1_WEL]  = c.write_enable_latch;
    b[S1_BP0]  = c.bp[0];
    b[S1_BP1]  = c.bp[1];
    b[S1_DEEP] = c.deepSleep;
    b[S1_AUTO_POWERDOWN_ENABLE_BIT] = c.auto_powerdown_enable_bit;
    b[S1_LOW_POWER_STANDBY_ENABLE_BIT] = c.low_power_standby_enable_bit;
    b[S1_STATUS_WRITE_DISABLE_BIT] = c.status_write_disable_bit;
    return b;
  endfunction : statusByte

  secc_link #(
    .AW (AW),
    .PB (PB)
  ) u_link (
    .sck       (sck),
    .csN       (csN),
    .rstn      (rstn),
    .sdi       (sdi),
    .memRdData (memRdData),
    .linkState (q.linkState),
    .memRdAddr (memRdAddr),
    .opcode    (opcode),
    .bitPhase  (bitPhase),
    .byteCnt   (byteCnt),
    .addr      (addr),
    .pageData  (pageData),
    .pageValid (pageValid),
    .sdo       (sdo),
    .sdoOe     (sdoOe)
  );

  assign memRdData = mem[memRdAddr];

  always_comb begin
    d          = q;
    memWe      = 1'b0;
    memWa      = '0;
    memWd      = '0;
    wrAddr     = '0;
    newStatus  = addr[15:8];

    // Pins pass three flops; a level is taken once the last two agree
    d.csSync = {q.csSync[1:0], csN};
    d.wpSync = {q.wpSync[1:0], wpN};
    if (q.csSync[1] == q.csSync[2]) begin
      d.csLevel = q.csSync[2];
    end
    if (q.wpSync[1] == q.wpSync[2]) begin
      d.wpLevel = q.wpSync[2];
    end
    frameEnd = (q.csSync[1] == q.csSync[2]) && q.csSync[2] && !q.csLevel;

    // Link frame registers are frozen once csN is high, so reading them here is safe
    wholeBytes = (bitPhase == 3'h0) && (byteCnt != 8'h00);
    hwLocked   = q.status_write_disable_bit && !q.wpLevel;

    if (q.deepSleep && deepSleepExit) begin
      d.deepSleep = 1'b0;
    end

    case (q.state)
      ST_IDLE: begin
        // Frames are only looked at when no internal cycle runs
        if (frameEnd && wholeBytes && !q.deepSleep) begin
          if (q.powerDown) begin
            if (opcode == OP_RESUME) begin
              d.powerDown = 1'b0;
            end
          end else if (needsLatch(opcode) && !q.write_enable_latch) begin
            d.write_enable_latch = q.write_enable_latch;
          end else begin
            case (opcode)
              OP_WRITE_ENABLE: begin
                d.write_enable_latch = 1'b1;
              end
              OP_WRITE_DISABLE: begin
                d.write_enable_latch = 1'b0;
              end
              OP_WRITE: begin
                if (byteCnt >= WRITE_MIN_BYTES) begin
                  d.write_in_progress_flag      = 1'b1;
                  d.state    = ST_PAGE;
                  d.job      = JOB_MEM;
                  d.idx      = '0;
                  d.pageBase = {addr[AW-1:PW], {PW{1'b0}}};
                end
              end
              OP_STATUS1_WRITE: begin
                // Whole status byte is frozen while the pin holds it locked
                if (byteCnt >= STATUS_WR_BYTES && !hwLocked) begin
                  d.bp[0]  = newStatus[S1_BP0];
                  d.bp[1]  = newStatus[S1_BP1];
                  d.auto_powerdown_enable_bit   = newStatus[S1_AUTO_POWERDOWN_ENABLE_BIT];
                  d.low_power_standby_enable_bit   = newStatus[S1_LOW_POWER_STANDBY_ENABLE_BIT];
                  d.status_write_disable_bit   = newStatus[S1_STATUS_WRITE_DISABLE_BIT];
                  d.write_in_progress_flag    = 1'b1;
                  d.state  = ST_WAIT;
                  d.job    = JOB_STS1;
                  d.timer  = 16'(ST_CYC);
                end
              end
              OP_STATUS2_WRITE: begin
                if (byteCnt >= STATUS_WR_BYTES) begin
                  d.slow_oscillator_bit  = newStatus[S2_SLOW];
                  d.autoDeep = newStatus[S2_AUTO_ULTRA_DEEP_SLEEP_BIT];
                  d.write_in_progress_flag      = 1'b1;
                  d.state    = ST_WAIT;
                  d.job      = JOB_STS2;
                  d.timer    = 16'(ST_CYC);
                end
              end
              OP_PAGE_ERASE: begin
                // Array contents are not touched by erase here; only the latch effect is kept
                if (byteCnt >= ERASE_PAGE_BYTES) begin
                  d.write_enable_latch = 1'b0;
                end
              end
              OP_CHIP_ERASE_A,
              OP_CHIP_ERASE_B: begin
                d.write_enable_latch = 1'b0;
              end
              OP_POWER_DOWN: begin
                d.write_enable_latch       = 1'b0;
                d.powerDown = 1'b1;
              end
              default: begin
                d.write_enable_latch = q.write_enable_latch;
              end
            endcase
          end
        end
      end

      ST_PAGE: begin
        // One buffer slot per clock; slots never filled leave the array alone
        wrAddr = q.pageBase | AW'(q.idx);
        if (pageValid[q.idx] && !isProtected(q.bp, wrAddr)) begin
          memWe = 1'b1;
          memWa = wrAddr;
          memWd = pageData[q.idx*8 +: 8];
        end
        d.idx = q.idx + 1'b1;
        if (q.idx == PW'(PB - 1)) begin
          d.state = ST_WAIT;
          d.timer = 16'(WR_CYC);
        end
      end

      ST_WAIT: begin
        // Slow mode only counts every other clock, doubling the cycle
        d.slowTick = ~q.slowTick;
        if (!q.slow_oscillator_bit || q.slowTick) begin
          d.timer = q.timer - 16'h0001;
        end
        if (q.timer == 16'h0000) begin
          d.write_in_progress_flag      = 1'b0;
          d.write_enable_latch      = 1'b0;
          d.slowTick = 1'b0;
          d.state    = ST_IDLE;
          if (q.autoDeep && q.job != JOB_STS2) begin
            d.deepSleep = 1'b1;
          end
        end
      end

      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Registered copy for the link side; it goes through two sck flops there
    d.linkState = {d.deepSleep | d.powerDown, d.state != ST_IDLE, statusByte(d)};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q         <= '0;
      q.csSync  <= 3'h7;
      q.wpSync  <= 3'h7;
      q.csLevel <= 1'b1;
      q.wpLevel <= 1'b1;
      q.bp      <= STATUS1_RESET[S1_BP1:S1_BP0];
      q.slow_oscillator_bit <= STATUS2_RESET[S2_SLOW];
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  assign writeBusy         = q.write_in_progress_flag;
  assign deepSleep         = q.deepSleep;
  assign powerDown         = q.powerDown;
  assign autoPowerDownEn   = q.auto_powerdown_enable_bit;
  assign lowPowerStandbyEn = q.low_power_standby_enable_bit;
endmodule : secc_core

// File: tb/secc_host.sv
`timescale 1ns/10ps
module secc_host #(
  parameter int HALF = 15,
  parameter int GAP  = 300
) (
  output logic      sck,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end

  // Mode 0 master; sck stands low between frames, so the link clock only runs inside a frame
  task automatic xfer(input logic [7:0] tx[$], input int nBits, output logic [7:0] rx[$]);
    logic [7:0] cur;
    rx = {};
    cur = 8'h00;
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      sdi = tx[i/8][7-i%8];
      #HALF sck = 1'b1;
      cur = {cur[6:0], sdo};
      if (i % 8 == 7) rx.push_back(cur);
      #HALF sck = 1'b0;
    end
    #HALF csN = 1'b1;
    // Released line shows the inverse so a stale value is never mistaken for data
    sdi = ~sdi;
    #GAP;
  endtask : xfer
endmodule : secc_host

// File: tb/secc_core_sva.sv
`timescale 1ns/10ps
module secc_core_sva #(
  parameter int WR_CYC = 64,
  parameter int ST_CYC = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic csN,
  input wire logic sdi,
  input wire logic wpN,
  input wire logic deepSleepExit,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic writeBusy,
  input wire logic deepSleep,
  input wire logic powerDown,
  input wire logic autoPowerDownEn,
  input wire logic lowPowerStandbyEn
);
  // Page copy, doubled write time under the slow oscillator, plus sync slack
  localparam int BUSY_MAX = 48 + 2 * WR_CYC + ST_CYC;
  int unsigned busyCnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busyCnt_q <= 0;
    else busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_oe_cs_idle: assert property (csN |-> !sdoOe)
    else $error("sdoOe high while deselected");
  a_sdo_cs_idle: assert property (csN |-> !sdo)
    else $error("sdo high while deselected");
  a_busy_after_cs: assert property ($rose(writeBusy) |-> csN && $past(csN, 2))
    else $error("write cycle started inside a frame");
  a_busy_bounded: assert property (busyCnt_q <= BUSY_MAX)
    else $error("write cycle too long");
  a_busy_min_len: assert property ($rose(writeBusy) |=> writeBusy[*2])
    else $error("write cycle too short");
  a_sleep_no_busy: assert property (deepSleep |-> !writeBusy)
    else $error("busy during deep sleep");
  a_sleep_exit_pin: assert property (deepSleep && deepSleepExit |-> ##[1:2] !deepSleep)
    else $error("deep sleep not left");
  a_sleep_after_wr: assert property ($rose(deepSleep) |->
    csN && ($past(writeBusy, 1) || $past(writeBusy, 2) || $past(writeBusy, 3)))
    else $error("deep sleep without a finished write");
  a_status_cs_high: assert property ($changed(autoPowerDownEn) || $changed(lowPowerStandbyEn) |-> csN)
    else $error("status bits changed inside a frame");

  c_write: cover property ($rose(writeBusy));
  c_sleep: cover property ($rose(deepSleep));
  c_drive: cover property ($rose(sdoOe));
endmodule : secc_core_sva

// File: tb/tb_spi_eeprom_command_core.sv
`timescale 1ns/10ps
module tb_spi_eeprom_command_core;
  import secc_pkg::*;
  logic       clk, rstn, wpN, deepSleepExit;
  logic       sck, csN, sdi, sdo, sdoOe, writeBusy;
  logic       deepSleep, powerDown, autoPowerDownEn, lowPowerStandbyEn;
  int         errors, n_compared, cyc, c1;
  logic [7:0] rx[$];
  logic [7:0] page[$];
  logic [7:0] st;

  initial clk = 1'b0;
  always #20 clk = ~clk;

  secc_core #(.WR_CYC(24), .ST_CYC(16)) dut (
    .clk(clk), .rstn(rstn), .sck(sck), .csN(csN), .sdi(sdi), .wpN(wpN),
    .deepSleepExit(deepSleepExit), .sdo(sdo), .sdoOe(sdoOe), .writeBusy(writeBusy),
    .deepSleep(deepSleep), .powerDown(powerDown), .autoPowerDownEn(autoPowerDownEn),
    .lowPowerStandbyEn(lowPowerStandbyEn)
  );
  secc_host host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic send(input logic [7:0] tx[$], input int nBits = 0);
    @(posedge clk);
    #1;
    host.xfer(tx, (nBits == 0) ? tx.size() * 8 : nBits, rx);
  endtask : send

  task automatic chk_st(input logic [7:0] exp, input logic [7:0] mask);
    send({OP_STATUS_READ, 8'h00});
    st = rx[1];
    check("status", exp, st & mask);
  endtask : chk_st

  task automatic wait_idle(output int n);
    n = 0;
    while (writeBusy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 2000) begin
        check("writeBusy", 8'h00, {7'h0, writeBusy});
        finish_test();
      end
    end
  endtask : wait_idle

  initial begin
    errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    wpN = 1'b1;
    deepSleepExit = 1'b0;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    chk_st(8'h00, 8'hFF);
    send({OP_WRITE_ENABLE}, 7);
    chk_st(8'h00, 8'h02);
    send({OP_WRITE_ENABLE});
    chk_st(8'h02, 8'hFF);
    send({OP_WRITE_DISABLE, 8'h00}, 12);
    chk_st(8'h02, 8'h02);
    @(posedge clk);
    #1 wpN = 1'b0;
    send({OP_WRITE_DISABLE});
    chk_st(8'h00, 8'h02);
    @(posedge clk);
    #1 wpN = 1'b1;
    // 34 bytes from offset 0: the first two are overwritten by the page wrap
    page = {OP_WRITE, 8'h00, 8'h00};
    for (int i = 0; i < 34; i++) page.push_back(8'(i));
    send({OP_WRITE_ENABLE});
    send(page);
    check("busy", 8'h01, {7'h0, writeBusy});
    chk_st(8'h01, 8'h01);
    send({OP_WRITE_ENABLE});
    wait_idle(cyc);
    chk_st(8'h00, 8'h03);
    send({OP_WRITE_ENABLE});
    send({OP_WRITE, 8'h00, 8'h1F, 8'hAA, 8'hBB});
    wait_idle(cyc);
    send({OP_READ, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF});
    check("rd0", 8'hBB, rx[3]);
    check("rd1", 8'h21, rx[4]);
    check("rd2", 8'h02, rx[5]);
    send({OP_FAST_READ, 8'h00, 8'h1E, 8'hFF, 8'h00, 8'h00});
    check("fr0", 8'h1E, rx[4]);
    check("fr1", 8'hAA, rx[5]);
    send({OP_WRITE_ENABLE});
    send({OP_WRITE, 8'h0F, 8'hFF, 8'h5A});
    wait_idle(c1);
    send({OP_READ, 8'h0F, 8'hFF, 8'h00, 8'h00});
    check("top", 8'h5A, rx[3]);
    check("wrap", 8'hBB, rx[4]);
    send({OP_WRITE, 8'h00, 8'h00, 8'h77});
    check("busy", 8'h00, {7'h0, writeBusy});
    send({OP_READ, 8'h00, 8'h00, 8'h00});
    check("rd0", 8'hBB, rx[3]);
    send({OP_WRITE_ENABLE});
    send({OP_STATUS1_WRITE, 8'hFF});
    wait_idle(cyc);
    chk_st(8'hEC, 8'hFF);
    check("pins", 8'h03, {6'h0, autoPowerDownEn, lowPowerStandbyEn});
    @(posedge clk);
    #1 wpN = 1'b0;
    send({OP_WRITE_ENABLE});
    send({OP_STATUS1_WRITE, 8'h00});
    wait_idle(cyc);
    chk_st(8'hEE, 8'hFF);
    @(posedge clk);
    #1 wpN = 1'b1;
    send({OP_STATUS1_WRITE, 8'h00});
    wait_idle(cyc);
    chk_st(8'h00, 8'hFF);
    send({OP_STATUS2_WRITE, 8'h03});
    check("busy", 8'h00, {7'h0, writeBusy});
    send({OP_WRITE_ENABLE});
    send({OP_STATUS2_WRITE, 8'h03});
    check("busy", 8'h01, {7'h0, writeBusy});
    wait_idle(cyc);
    chk_st(8'h00, 8'h03);
    send({OP_WRITE_ENABLE});
    send({OP_WRITE, 8'h0F, 8'hFF, 8'hA5});
    wait_idle(cyc);
    check("slow", 8'h01, {7'h0, cyc > c1});
    repeat (4) @(posedge clk);
    check("sleep", 8'h01, {7'h0, deepSleep});
    #1 deepSleepExit = 1'b1;
    @(posedge clk);
    #1 deepSleepExit = 1'b0;
    repeat (4) @(posedge clk);
    check("sleep", 8'h00, {7'h0, deepSleep});
    send({OP_POWER_DOWN});
    check("pdown", 8'h01, {7'h0, powerDown});
    send({OP_RESUME});
    check("pdown", 8'h00, {7'h0, powerDown});
    finish_test();
  end
endmodule : tb_spi_eeprom_command_core

bind secc_core secc_core_sva #(.WR_CYC(WR_CYC), .ST_CYC(ST_CYC)) u_sva (
  .clk(clk), .rstn(rstn), .sck(sck), .csN(csN), .sdi(sdi), .wpN(wpN),
  .deepSleepExit(deepSleepExit), .sdo(sdo), .sdoOe(sdoOe), .writeBusy(writeBusy),
  .deepSleep(deepSleep), .powerDown(powerDown), .autoPowerDownEn(autoPowerDownEn),
  .lowPowerStandbyEn(lowPowerStandbyEn)
);
